// ---- rtl/tcc_defines.svh ----
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH

// ************************************************************
// register offsets
// ************************************************************
`define TCC_ADDR_PORT_DIR   16'hff27
`define TCC_ADDR_MODE_CTRL  16'hff60
`define TCC_ADDR_PRESCALE   16'hff61
`define TCC_ADDR_CC_CTRL    16'hff62
`define TCC_ADDR_OUT_CTRL   16'hff63

// ************************************************************
// reset values
// ************************************************************
`define TCC_RST_PORT_DIR    8'hff
`define TCC_RST_MODE_CTRL   8'h00
`define TCC_RST_PRESCALE    8'h00
`define TCC_RST_CC_CTRL     8'h00
`define TCC_RST_OUT_CTRL    8'h00

// ************************************************************
// field positions
// ************************************************************
`define TCC_MODE_WRAP_BIT   0
`define TCC_MODE_OTIM_BIT   1
`define TCC_MODE_RUN_LSB    2
`define TCC_MODE_RUN_MSB    3
`define TCC_CC_ACAP_BIT     0
`define TCC_CC_ATRIG_BIT    1
`define TCC_CC_BCAP_BIT     2
`define TCC_OC_OE_BIT       0
`define TCC_OC_TOGA_BIT     1
`define TCC_OC_FLOW_BIT     2
`define TCC_OC_FHIGH_BIT    3
`define TCC_OC_TOGB_BIT     4
`define TCC_OC_ONESHOT_SW_TRIGGER_BIT     5
`define TCC_PR_CLK_LSB      0
`define TCC_PR_CLK_MSB      1
`define TCC_PR_EA_LSB       4
`define TCC_PR_EA_MSB       5
`define TCC_PR_EB_LSB       6
`define TCC_PR_EB_MSB       7
`define TCC_PD_BITS_MSB     1

// ************************************************************
// count clock dividers and counter limits
// ************************************************************
`define TCC_DIV2_MASK       7'h01
`define TCC_DIV16_MASK      7'h0f
`define TCC_DIV128_MASK     7'h7f
`define TCC_CNT_MAX         16'hffff
`define TCC_CNT_ZERO        16'h0000

`endif

// ---- rtl/tcc_pkg.sv ----
package tcc_pkg;

  typedef enum logic [1:0] {
    TCC_RUN_STOP  = 2'h0,
    TCC_RUN_FREE  = 2'h1,
    TCC_RUN_ECLR  = 2'h2,
    TCC_RUN_MCLR  = 2'h3
  } tcc_run_t;

  typedef enum logic [1:0] {
    TCC_EDGE_FALL = 2'h0,
    TCC_EDGE_RISE = 2'h1,
    TCC_EDGE_BAD  = 2'h2,
    TCC_EDGE_BOTH = 2'h3
  } tcc_edge_t;

  typedef enum logic [1:0] {
    TCC_CLK_DIV2   = 2'h0,
    TCC_CLK_DIV16  = 2'h1,
    TCC_CLK_DIV128 = 2'h2,
    TCC_CLK_EDGEA  = 2'h3
  } tcc_clk_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } tcc_bus_req_t;

  typedef struct packed {
    logic        wr_a;
    logic        wr_b;
    logic [15:0] wdata;
  } tcc_cmp_wr_t;

  typedef struct packed {
    logic        sync_a1;
    logic        sync_a2;
    logic        sync_b1;
    logic        sync_b2;
    logic [6:0]  pre;
    logic [2:0]  hist_a;
    logic [2:0]  hist_b;
    logic [15:0] cnt;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    tcc_run_t    run_mode;
    logic        out_timing;
    logic        wrap;
    logic        b_cap;
    logic        a_trig;
    logic        a_cap;
    logic        tog_b;
    logic        tog_a;
    logic        out_en;
    tcc_edge_t   edge_b_sel;
    tcc_edge_t   edge_a_sel;
    tcc_clk_t    clk_sel;
    logic [1:0]  pin_dir;
    logic        wave;
    logic        pin_out;
    logic        pin_oe_n;
    logic        irq_a;
    logic        irq_b;
    logic [7:0]  rdata;
  } tcc_state_t;

endpackage

// ---- rtl/tcc_timer.sv ----
`timescale 1ns/1ps
`include "tcc_defines.svh"

module tcc_timer
  import tcc_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  input  wire tcc_bus_req_t bus_req,
  output logic [7:0]        bus_rdata,
  input  wire tcc_cmp_wr_t  cmp_wr,
  input  wire logic         port_latch0,
  input  wire logic         pin0_in,
  output logic              pin0_out,
  output logic              pin0_oe_n,
  input  wire logic         edge_in_b,
  output logic [15:0]       count_value,
  output logic [15:0]       cmp_cap_a,
  output logic [15:0]       cmp_cap_b,
  output logic              match_a_irq,
  output logic              match_b_irq
);

  tcc_state_t st_ff;
  tcc_state_t nxt_st;

  // ************************************************************
  // combinational helpers
  // ************************************************************
  logic [6:0]  div_mask;
  logic        div_tick;
  logic        sample_en;
  logic [2:0]  new_ha;
  logic [2:0]  new_hb;
  logic        rise_a;
  logic        fall_a;
  logic        rise_b;
  logic        fall_b;
  logic        valid_a;
  logic        opp_a;
  logic        valid_b;
  logic        tick;
  logic        running;
  logic        hit_a;
  logic        hit_b;
  logic        cap_a;
  logic        cap_b;
  logic        flip;
  logic        wr_mode;
  logic        wr_pre;
  logic        wr_cc;
  logic        wr_oc;
  logic        wr_pd;

  always_comb begin
    // ************************************************************
    // count clock selection
    // ************************************************************
    unique case (st_ff.clk_sel)
      TCC_CLK_DIV2:   div_mask = `TCC_DIV2_MASK;
      TCC_CLK_DIV16:  div_mask = `TCC_DIV16_MASK;
      TCC_CLK_DIV128: div_mask = `TCC_DIV128_MASK;
      TCC_CLK_EDGEA:  div_mask = `TCC_DIV2_MASK;
    endcase
    div_tick  = ((st_ff.pre & div_mask) == div_mask);
    // edge A as count clock needs every cycle sampled, else edges are missed
    sample_en = (st_ff.clk_sel == TCC_CLK_EDGEA) ? 1'b1 : div_tick;

    // ************************************************************
    // edge qualification
    // ************************************************************
    // a level must be seen twice before the edge counts, filtering glitches
    new_ha = {st_ff.hist_a[1:0], st_ff.sync_a2};
    new_hb = {st_ff.hist_b[1:0], st_ff.sync_b2};
    rise_a = sample_en && (new_ha == 3'h3);
    fall_a = sample_en && (new_ha == 3'h4);
    rise_b = sample_en && (new_hb == 3'h3);
    fall_b = sample_en && (new_hb == 3'h4);

    unique case (st_ff.edge_a_sel)
      TCC_EDGE_FALL: begin
        valid_a = fall_a;
        opp_a   = rise_a;
      end
      TCC_EDGE_RISE: begin
        valid_a = rise_a;
        opp_a   = fall_a;
      end
      TCC_EDGE_BOTH: begin
        valid_a = rise_a | fall_a;
        opp_a   = 1'b0;
      end
      TCC_EDGE_BAD: begin
        valid_a = 1'b0;
        opp_a   = 1'b0;
      end
    endcase

    unique case (st_ff.edge_b_sel)
      TCC_EDGE_FALL: valid_b = fall_b;
      TCC_EDGE_RISE: valid_b = rise_b;
      TCC_EDGE_BOTH: valid_b = rise_b | fall_b;
      TCC_EDGE_BAD:  valid_b = 1'b0;
    endcase

    // ************************************************************
    // count events
    // ************************************************************
    running = (st_ff.run_mode != TCC_RUN_STOP);
    // edge A as clock must not also clear or capture: software keeps it apart
    tick    = running && ((st_ff.clk_sel == TCC_CLK_EDGEA) ? valid_a : div_tick);
    hit_a   = tick && (st_ff.cnt == st_ff.cmp_a);
    hit_b   = tick && (st_ff.cnt == st_ff.cmp_b);
    // capture in match-clear mode is left to software to avoid
    cap_b   = running && st_ff.b_cap && valid_a;
    cap_a   = running && st_ff.a_cap && (st_ff.a_trig ? opp_a : valid_b);

    // ************************************************************
    // register decode
    // ************************************************************
    wr_mode = bus_req.wr && (bus_req.addr == `TCC_ADDR_MODE_CTRL);
    wr_pre  = bus_req.wr && (bus_req.addr == `TCC_ADDR_PRESCALE);
    wr_cc   = bus_req.wr && (bus_req.addr == `TCC_ADDR_CC_CTRL);
    wr_oc   = bus_req.wr && (bus_req.addr == `TCC_ADDR_OUT_CTRL);
    wr_pd   = bus_req.wr && (bus_req.addr == `TCC_ADDR_PORT_DIR);

    nxt_st = st_ff;

    // ************************************************************
    // synchronisers and sampling
    // ************************************************************
    nxt_st.sync_a1 = pin0_in;
    nxt_st.sync_a2 = st_ff.sync_a1;
    nxt_st.sync_b1 = edge_in_b;
    nxt_st.sync_b2 = st_ff.sync_b1;
    nxt_st.pre     = st_ff.pre + 7'h01;
    if (sample_en) begin
      nxt_st.hist_a = new_ha;
      nxt_st.hist_b = new_hb;
    end

    // ************************************************************
    // counter
    // ************************************************************
    if (!running) begin
      nxt_st.cnt = `TCC_CNT_ZERO;
    end else if ((st_ff.run_mode == TCC_RUN_ECLR) && valid_a) begin
      nxt_st.cnt = `TCC_CNT_ZERO;
    end else if (tick) begin
      if ((st_ff.run_mode == TCC_RUN_MCLR) && hit_a) begin
        nxt_st.cnt = `TCC_CNT_ZERO;
      end else begin
        nxt_st.cnt = st_ff.cnt + 16'h0001;
      end
    end

    // ************************************************************
    // compare / capture registers
    // ************************************************************
    if (cmp_wr.wr_a) begin
      nxt_st.cmp_a = cmp_wr.wdata;
    end
    if (cmp_wr.wr_b) begin
      nxt_st.cmp_b = cmp_wr.wdata;
    end
    // a capture beats a simultaneous software write
    if (cap_a) begin
      nxt_st.cmp_a = st_ff.cnt;
    end
    if (cap_b) begin
      nxt_st.cmp_b = st_ff.cnt;
    end

    // ************************************************************
    // interrupt pulses
    // ************************************************************
    nxt_st.irq_a = (hit_a && !st_ff.a_cap) || cap_a;
    nxt_st.irq_b = (hit_b && !st_ff.b_cap) || cap_b;

    // ************************************************************
    // output flip-flop
    // ************************************************************
    flip = 1'b0;
    if (running) begin
      if (hit_a && !st_ff.a_cap && st_ff.tog_a) begin
        flip = ~flip;
      end
      if (hit_b && !st_ff.b_cap && st_ff.tog_b) begin
        flip = ~flip;
      end
      if (st_ff.out_timing && valid_a && (st_ff.run_mode != TCC_RUN_ECLR)) begin
        flip = ~flip;
      end
    end
    nxt_st.wave = st_ff.wave ^ flip;
    // both force bits together is illegal; software never writes it
    if (wr_oc) begin
      if (bus_req.wdata[`TCC_OC_FHIGH_BIT] && !bus_req.wdata[`TCC_OC_FLOW_BIT]) begin
        nxt_st.wave = 1'b1;
      end else if (!bus_req.wdata[`TCC_OC_FHIGH_BIT] && bus_req.wdata[`TCC_OC_FLOW_BIT]) begin
        nxt_st.wave = 1'b0;
      end
    end

    // ************************************************************
    // pin drive
    // ************************************************************
    nxt_st.pin_out  = st_ff.out_en ? st_ff.wave : port_latch0;
    nxt_st.pin_oe_n = st_ff.pin_dir[0];

    // ************************************************************
    // register writes
    // ************************************************************
    // reconfiguring while running is undefined; software stops first
    if (wr_mode) begin
      nxt_st.run_mode   = tcc_run_t'(bus_req.wdata[`TCC_MODE_RUN_MSB:`TCC_MODE_RUN_LSB]);
      nxt_st.out_timing = bus_req.wdata[`TCC_MODE_OTIM_BIT];
      nxt_st.wrap       = bus_req.wdata[`TCC_MODE_WRAP_BIT];
    end
    // hardware set wins over a clearing write in the same cycle
    if (tick && (st_ff.cnt == `TCC_CNT_MAX) && (nxt_st.cnt == `TCC_CNT_ZERO)) begin
      nxt_st.wrap = 1'b1;
    end
    if (wr_pre) begin
      nxt_st.edge_b_sel = tcc_edge_t'(bus_req.wdata[`TCC_PR_EB_MSB:`TCC_PR_EB_LSB]);
      nxt_st.edge_a_sel = tcc_edge_t'(bus_req.wdata[`TCC_PR_EA_MSB:`TCC_PR_EA_LSB]);
      nxt_st.clk_sel    = tcc_clk_t'(bus_req.wdata[`TCC_PR_CLK_MSB:`TCC_PR_CLK_LSB]);
    end
    if (wr_cc) begin
      nxt_st.b_cap  = bus_req.wdata[`TCC_CC_BCAP_BIT];
      nxt_st.a_trig = bus_req.wdata[`TCC_CC_ATRIG_BIT];
      nxt_st.a_cap  = bus_req.wdata[`TCC_CC_ACAP_BIT];
    end
    if (wr_oc) begin
      nxt_st.tog_b  = bus_req.wdata[`TCC_OC_TOGB_BIT];
      nxt_st.tog_a  = bus_req.wdata[`TCC_OC_TOGA_BIT];
      nxt_st.out_en = bus_req.wdata[`TCC_OC_OE_BIT];
    end
    if (wr_pd) begin
      nxt_st.pin_dir = bus_req.wdata[`TCC_PD_BITS_MSB:0];
    end

    // ************************************************************
    // register reads
    // ************************************************************
    nxt_st.rdata = 8'h00;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        `TCC_ADDR_MODE_CTRL: begin
          nxt_st.rdata[`TCC_MODE_RUN_MSB:`TCC_MODE_RUN_LSB] = st_ff.run_mode;
          nxt_st.rdata[`TCC_MODE_OTIM_BIT]                  = st_ff.out_timing;
          nxt_st.rdata[`TCC_MODE_WRAP_BIT]                  = st_ff.wrap;
        end
        `TCC_ADDR_PRESCALE: begin
          nxt_st.rdata[`TCC_PR_EB_MSB:`TCC_PR_EB_LSB]   = st_ff.edge_b_sel;
          nxt_st.rdata[`TCC_PR_EA_MSB:`TCC_PR_EA_LSB]   = st_ff.edge_a_sel;
          nxt_st.rdata[`TCC_PR_CLK_MSB:`TCC_PR_CLK_LSB] = st_ff.clk_sel;
        end
        `TCC_ADDR_CC_CTRL: begin
          nxt_st.rdata[`TCC_CC_BCAP_BIT]  = st_ff.b_cap;
          nxt_st.rdata[`TCC_CC_ATRIG_BIT] = st_ff.a_trig;
          nxt_st.rdata[`TCC_CC_ACAP_BIT]  = st_ff.a_cap;
        end
        `TCC_ADDR_OUT_CTRL: begin
          // force and one-shot strobes are never stored, so they read zero
          nxt_st.rdata[`TCC_OC_TOGB_BIT] = st_ff.tog_b;
          nxt_st.rdata[`TCC_OC_TOGA_BIT] = st_ff.tog_a;
          nxt_st.rdata[`TCC_OC_OE_BIT]   = st_ff.out_en;
        end
        `TCC_ADDR_PORT_DIR: begin
          nxt_st.rdata = {6'h3f, st_ff.pin_dir};
        end
        default: begin
          nxt_st.rdata = 8'h00;
        end
      endcase
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff            <= '0;
      st_ff.run_mode   <= tcc_run_t'(2'(`TCC_RST_MODE_CTRL >> `TCC_MODE_RUN_LSB));
      st_ff.out_timing <= 1'(`TCC_RST_MODE_CTRL >> `TCC_MODE_OTIM_BIT);
      st_ff.wrap       <= 1'(`TCC_RST_MODE_CTRL >> `TCC_MODE_WRAP_BIT);
      st_ff.edge_b_sel <= tcc_edge_t'(2'(`TCC_RST_PRESCALE >> `TCC_PR_EB_LSB));
      st_ff.edge_a_sel <= tcc_edge_t'(2'(`TCC_RST_PRESCALE >> `TCC_PR_EA_LSB));
      st_ff.clk_sel    <= tcc_clk_t'(2'(`TCC_RST_PRESCALE >> `TCC_PR_CLK_LSB));
      st_ff.b_cap      <= 1'(`TCC_RST_CC_CTRL >> `TCC_CC_BCAP_BIT);
      st_ff.a_trig     <= 1'(`TCC_RST_CC_CTRL >> `TCC_CC_ATRIG_BIT);
      st_ff.a_cap      <= 1'(`TCC_RST_CC_CTRL >> `TCC_CC_ACAP_BIT);
      st_ff.tog_b      <= 1'(`TCC_RST_OUT_CTRL >> `TCC_OC_TOGB_BIT);
      st_ff.tog_a      <= 1'(`TCC_RST_OUT_CTRL >> `TCC_OC_TOGA_BIT);
      st_ff.out_en     <= 1'(`TCC_RST_OUT_CTRL >> `TCC_OC_OE_BIT);
      st_ff.pin_dir    <= 2'(`TCC_RST_PORT_DIR);
      // pin stays released until software claims it as an output
      st_ff.pin_oe_n   <= 1'(`TCC_RST_PORT_DIR);
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign bus_rdata   = st_ff.rdata;
  assign pin0_out    = st_ff.pin_out;
  assign pin0_oe_n   = st_ff.pin_oe_n;
  assign count_value = st_ff.cnt;
  assign cmp_cap_a   = st_ff.cmp_a;
  assign cmp_cap_b   = st_ff.cmp_b;
  assign match_a_irq = st_ff.irq_a;
  assign match_b_irq = st_ff.irq_b;

endmodule

// ---- tb/tcc_timer_asserts.sv ----
`timescale 1ns/1ps
// ************************************************************
// timer port checker
// ************************************************************
module tcc_timer_asserts
  import tcc_pkg::*;
(
  input wire logic         ref_clk,
  input wire logic         reset_n,
  input wire tcc_bus_req_t bus_req,
  input wire logic [7:0]   bus_rdata,
  input wire tcc_cmp_wr_t  cmp_wr,
  input wire logic         port_latch0,
  input wire logic         pin0_in,
  input wire logic         pin0_out,
  input wire logic         pin0_oe_n,
  input wire logic         edge_in_b,
  input wire logic [15:0]  count_value,
  input wire logic [15:0]  cmp_cap_a,
  input wire logic [15:0]  cmp_cap_b,
  input wire logic         match_a_irq,
  input wire logic         match_b_irq
);
  logic [1:0] mode_ff;
  logic [1:0] clk_ff;
  logic       acap_ff;
  logic       bcap_ff;
  logic       oe_ff;

  // shadows move on the same edge as the design's own registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_ff <= 2'h0;
      clk_ff  <= 2'h0;
      acap_ff <= 1'b0;
      bcap_ff <= 1'b0;
      oe_ff   <= 1'b0;
    end else if (bus_req.wr) begin
      case (bus_req.addr)
        16'hff60: mode_ff <= bus_req.wdata[3:2];
        16'hff61: clk_ff <= bus_req.wdata[1:0];
        16'hff62: {bcap_ff, acap_ff} <= {bus_req.wdata[2], bus_req.wdata[0]};
        16'hff63: oe_ff <= bus_req.wdata[0];
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  stop_clear_a: assert property (
    mode_ff == 2'h0 && $past(mode_ff) == 2'h0 |-> count_value == 16'h0 && !match_a_irq && !match_b_irq)
    else $error("count or irq active while stopped");
  count_step_a: assert property (
    $changed(count_value) |-> count_value == $past(count_value) + 16'h1 || count_value == 16'h0)
    else $error("count moved by more than one");
  div2_rate_a: assert property (
    mode_ff == 2'h1 && clk_ff == 2'h0 && $changed(count_value) |=> $stable(count_value))
    else $error("count ticks faster than half rate");
  match_a_cause_a: assert property (
    match_a_irq && !acap_ff |-> $past(count_value) == cmp_cap_a)
    else $error("match a irq without equal count");
  match_b_cause_a: assert property (
    match_b_irq && !bcap_ff |-> $past(count_value) == cmp_cap_b)
    else $error("match b irq without equal count");
  match_a_seen_a: assert property (
    (mode_ff == 2'h1 || mode_ff == 2'h3) && !acap_ff && $changed(count_value)
      && $past(count_value) == cmp_cap_a |-> match_a_irq)
    else $error("match a passed without irq");
  match_clear_a: assert property (
    mode_ff == 2'h3 && match_a_irq |-> count_value == 16'h0 ##[1:300] count_value == 16'h1)
    else $error("match clear did not restart from zero");
  strobe_zero_a: assert property (
    $past(bus_req.rd) && $past(bus_req.addr) == 16'hff63 |-> (bus_rdata & 8'hec) == 8'h00)
    else $error("strobe bits read back nonzero");
  port_route_a: assert property (
    !oe_ff && !$past(oe_ff) |-> pin0_out == $past(port_latch0))
    else $error("pin not under port control");
  force_level_a: assert property (
    bus_req.wr && bus_req.addr == 16'hff63 && bus_req.wdata[0] && (bus_req.wdata[3] ^ bus_req.wdata[2])
      |-> ##3 pin0_out == $past(bus_req.wdata[3], 3))
    else $error("forced level not on pin");
endmodule

bind tcc_timer tcc_timer_asserts chk_u (.ref_clk, .reset_n, .bus_req, .bus_rdata, .cmp_wr, .port_latch0,
  .pin0_in, .pin0_out, .pin0_oe_n, .edge_in_b, .count_value, .cmp_cap_a, .cmp_cap_b, .match_a_irq, .match_b_irq);

// ---- tb/tcc_pin_model.sv ----
`timescale 1ns/1ps
// ************************************************************
// external edge source on the shared pin and edge b
// ************************************************************
module tcc_pin_model (
  input  wire logic ref_clk,
  input  wire logic pin0_out,
  input  wire logic pin0_oe_n,
  output logic      pin0_in,
  output logic      edge_in_b
);
  logic ext_a_ff;

  initial begin
    ext_a_ff  = 1'b0;
    edge_in_b = 1'b0;
  end

  // source backs off while the device drives the pin
  assign pin0_in = pin0_oe_n ? ext_a_ff : pin0_out;

  // long holds so div2 and edge A count clocks still sample the level twice
  task automatic drive(input logic is_b, input logic lvl, input int hold);
    @(negedge ref_clk);
    if (is_b) begin
      edge_in_b = lvl;
    end else begin
      ext_a_ff = lvl;
    end
    repeat (hold) @(negedge ref_clk);
  endtask
endmodule

// ---- tb/tcc_timer_tb.sv ----
`timescale 1ns/1ps
// ************************************************************
// timer register level bench
// ************************************************************
module tcc_timer_tb
  import tcc_pkg::*;
;
  logic         ref_clk;
  logic         reset_n;
  tcc_bus_req_t bus_req;
  logic [7:0]   bus_rdata;
  tcc_cmp_wr_t  cmp_wr;
  logic         port_latch0;
  logic         pin0_in;
  logic         pin0_out;
  logic         pin0_oe_n;
  logic         edge_in_b;
  logic [15:0]  count_value;
  logic [15:0]  cmp_cap_a;
  logic [15:0]  cmp_cap_b;
  logic         match_a_irq;
  logic         match_b_irq;
  int           mismatches;
  int           checks;
  int           n;
  logic [15:0]  snap;
  logic [15:0]  addr_tbl [6] = '{16'hff27, 16'hff60, 16'hff61, 16'hff62, 16'hff63, 16'hff64};
  logic [7:0]   rst_tbl [6]  = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  tcc_timer dut_u (.ref_clk, .reset_n, .bus_req, .bus_rdata, .cmp_wr, .port_latch0, .pin0_in, .pin0_out,
    .pin0_oe_n, .edge_in_b, .count_value, .cmp_cap_a, .cmp_cap_b, .match_a_irq, .match_b_irq);
  tcc_pin_model pin_u (.ref_clk, .pin0_out, .pin0_oe_n, .pin0_in, .edge_in_b);

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic finish_test();
    if (mismatches == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // extra idle cycles keep a forced level on the pin before the next write
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge ref_clk);
    bus_req.wr = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    bus_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge ref_clk);
    bus_req.rd = 1'b0;
    chk({8'h00, bus_rdata}, {8'h00, exp});
    @(negedge ref_clk);
  endtask

  task automatic cw(input logic b, input logic [15:0] v);
    cmp_wr = '{wr_a: !b, wr_b: b, wdata: v};
    @(negedge ref_clk);
    cmp_wr = '{wr_a: 1'b0, wr_b: 1'b0, wdata: v};
    @(negedge ref_clk);
  endtask

  task automatic wait_cnt(input logic [15:0] v);
    n = 0;
    while (count_value !== v && n < 1000) begin
      @(negedge ref_clk);
      n++;
    end
  endtask

  task automatic wait_irq(input logic b);
    n = 0;
    while ((b ? match_b_irq : match_a_irq) !== 1'b1 && n < 1000) begin
      @(negedge ref_clk);
      n++;
    end
    chk(n < 1000, 16'h1);
  endtask

  initial begin
    repeat (50000) @(posedge ref_clk);
    mismatches++;
    finish_test();
  end

  initial begin
    bus_req     = '0;
    cmp_wr      = '0;
    port_latch0 = 1'b0;
    mismatches  = 0;
    checks      = 0;
    reset_n     = 1'b0;
    repeat (2) @(negedge ref_clk);
    reset_n = 1'b1;
    @(negedge ref_clk);
    foreach (addr_tbl[i]) begin
      rd(addr_tbl[i], rst_tbl[i]);
    end
    wr(16'hff27, 8'hfe);
    wr(16'hff63, 8'h29);
    rd(16'hff63, 8'h01);
    chk(pin0_out, 16'h1);
    chk(pin0_oe_n, 16'h0);
    wr(16'hff63, 8'h01);
    chk(pin0_out, 16'h1);
    wr(16'hff63, 8'h05);
    chk(pin0_out, 16'h0);
    wr(16'hff63, 8'h08);
    chk(pin0_out, 16'h0);
    port_latch0 = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk(pin0_out, 16'h1);
    port_latch0 = 1'b0;
    wr(16'hff27, 8'hff);
    rd(16'hff27, 8'hff);
    cw(1'b0, 16'h0005);
    cw(1'b1, 16'h0008);
    for (int k = 0; k < 3; k++) begin
      wr(16'hff61, k[7:0]);
      wr(16'hff60, 8'h04);
      // at div2 the count may have stepped twice before the write returns
      wait_cnt(16'h3);
      wait_cnt(16'h5);
      chk(n[15:0], 16'h4 << (3 * k));
      wr(16'hff60, 8'h00);
      chk(count_value, 16'h0);
    end
    wr(16'hff60, 8'h04);
    wait_irq(1'b0);
    chk(count_value, 16'h6);
    wait_irq(1'b1);
    chk(count_value, 16'h9);
    wr(16'hff60, 8'h00);
    wr(16'hff27, 8'hfe);
    for (int t = 0; t < 2; t++) begin
      wr(16'hff63, t ? 8'h15 : 8'h07);
      wr(16'hff60, 8'h04);
      wait_irq(1'b0);
      repeat (2) @(negedge ref_clk);
      chk(pin0_out, t == 0);
      wait_irq(1'b1);
      repeat (2) @(negedge ref_clk);
      chk(pin0_out, 16'h1);
      wr(16'hff60, 8'h00);
    end
    wr(16'hff27, 8'hff);
    wr(16'hff63, 8'h00);
    cw(1'b0, 16'h0003);
    wr(16'hff60, 8'h0c);
    wait_irq(1'b0);
    chk(count_value, 16'h0);
    snap = 16'h0;
    // a full match period at the slowest count clock
    repeat (600) begin
      @(negedge ref_clk);
      snap = (count_value > snap) ? count_value : snap;
    end
    chk(snap, 16'h3);
    rd(16'hff60, 8'h0c);
    wr(16'hff60, 8'h00);
    wr(16'hff60, 8'h01);
    rd(16'hff60, 8'h01);
    wr(16'hff60, 8'h00);
    rd(16'hff60, 8'h00);
    wr(16'hff61, 8'h10);
    wr(16'hff60, 8'h08);
    wait_cnt(16'h14);
    pin_u.drive(1'b0, 1'b1, 16);
    chk(count_value < 16'h10, 16'h1);
    snap = count_value;
    pin_u.drive(1'b0, 1'b0, 16);
    chk(count_value > snap, 16'h1);
    wr(16'hff60, 8'h00);
    wr(16'hff63, 8'h05);
    wr(16'hff60, 8'h06);
    chk(pin0_out, 16'h0);
    pin_u.drive(1'b0, 1'b1, 16);
    chk(pin0_out, 16'h1);
    pin_u.drive(1'b0, 1'b0, 16);
    chk(pin0_out, 16'h1);
    wr(16'hff60, 8'h00);
    wr(16'hff61, 8'h13);
    wr(16'hff60, 8'h04);
    pin_u.drive(1'b0, 1'b1, 16);
    pin_u.drive(1'b0, 1'b0, 16);
    pin_u.drive(1'b0, 1'b1, 16);
    chk(count_value, 16'h2);
    pin_u.drive(1'b0, 1'b0, 16);
    wr(16'hff60, 8'h00);
    wr(16'hff62, 8'h04);
    wr(16'hff61, 8'h00);
    wr(16'hff60, 8'h04);
    pin_u.drive(1'b0, 1'b1, 16);
    chk(cmp_cap_b, 16'h8);
    pin_u.drive(1'b0, 1'b0, 16);
    snap = count_value;
    chk(cmp_cap_b < snap && cmp_cap_b > snap - 16'h8, 16'h1);
    wr(16'hff60, 8'h00);
    wr(16'hff62, 8'h01);
    wr(16'hff61, 8'h40);
    cw(1'b0, 16'hffff);
    wr(16'hff60, 8'h04);
    pin_u.drive(1'b1, 1'b1, 16);
    snap = count_value;
    chk(cmp_cap_a < snap && cmp_cap_a > snap - 16'h8, 16'h1);
    wr(16'hff60, 8'h00);
    wr(16'hff62, 8'h03);
    // rising valid edge first, then both edges where the opposite edge is void
    for (int e = 0; e < 2; e++) begin
      wr(16'hff61, e ? 8'h30 : 8'h10);
      cw(1'b0, 16'hffff);
      wr(16'hff60, 8'h04);
      pin_u.drive(1'b0, 1'b1, 16);
      chk(cmp_cap_a, 16'hffff);
      pin_u.drive(1'b0, 1'b0, 16);
      snap = count_value;
      chk(e ? (cmp_cap_a == 16'hffff) : (cmp_cap_a < snap && cmp_cap_a > snap - 16'h8), 16'h1);
      wr(16'hff60, 8'h00);
    end
    finish_test();
  end
endmodule
